// ==== hdl/sap_serial_port.sv ====
// frame sequencer, sar control, offset calibration and serial output
`timescale 1ns/10ps
`default_nettype none
//
// Overview of operation
// - select falling edge holds the sample and starts its conversion, or calibration in the power-up frame
// - serial clock falling edges alone pace conversion and shifting
// - analog inputs stay disconnected from the sampler while converting
// - after the last conversion step the sampler reconnects, acquiring
// - serial output driver turns on at the select falling edge
// - each serial clock falling edge launches the next output bit
// - select rising edge releases the serial output, ending the frame
// - two zeros, ten result bits, then output low after 12 clocks
// - power-up calibration commits only after 16 falls in frame one
// - normal calibration runs fall 17 to 32, else offset unchanged
// - result is straight unsigned binary, zero low, all ones full
module sap_serial_port
  import sap_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       csInN,
  input  wire logic       sclkIn,
  input  wire logic       cmpHighIn,
  output logic            sdoOut,
  output logic            sdoOe,
  output logic            samplerConnect,
  output logic            calActive,
  output logic [9:0]      dacCode,
  output logic [4:0]      trimCode,
  output logic            acqDone,
  output logic [9:0]      resultData,
  output logic            resultValid,
  input  wire logic       resultReady,
  output logic            resultOverrun
);
  logic [2:0]    syncQ;
  logic          csLvl;
  logic          sclkLvl;
  logic          cmpLvl;
  logic          csPrev_ff;
  logic          sclkPrev_ff;
  logic          csFall;
  logic          csRise;
  logic          sclkFall;
  sap_state_type state_ff;
  logic [5:0]    cnt_ff;
  logic [5:0]    nxtCnt;
  logic [9:0]    sar_ff;
  logic [9:0]    nxtSar;
  logic [3:0]    sarIdx;
  logic [4:0]    trial_ff;
  logic [4:0]    calTrim_ff;
  logic [9:0]    trimStep;
  logic [3:0]    trimIdx;
  logic [5:0]    calBase;
  logic [5:0]    calLast;
  logic [5:0]    calRel;
  logic          firstFrame_ff;
  logic          stConv;
  logic          stTail;
  logic          stCal;
  logic          convStep;
  logic          convDone;
  logic          calStep;
  logic          calDone;
  logic          calStartNrm;
  logic          sdoOut_ff;
  logic          sdoOe_ff;
  logic          nxtSdo;
  logic          pendValid_ff;
  logic [9:0]    pendData_ff;
  logic          overrun_ff;
  logic [3:0]    acqCnt_ff;

  sap_stream_if #(.WIDTH(RES_BITS)) pushIf ();
  sap_stream_if #(.WIDTH(RES_BITS)) popIf ();

  // select, clock and comparator all arrive from outside this domain
  sap_sync #(
    .WIDTH   (3),
    .RST_VAL (SYNC_RST_VAL)
  ) u_sync (
    .clk     (ref_clk),
    .reset   (reset),
    .asyncIn ({cmpHighIn, sclkIn, csInN}),
    .syncOut (syncQ)
  );

  assign csLvl   = syncQ[0];
  assign sclkLvl = syncQ[1];
  assign cmpLvl  = syncQ[2];

  // edge history on synchronised levels
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      csPrev_ff   <= 1'b1;
      sclkPrev_ff <= 1'b0;
    end else begin
      csPrev_ff   <= csLvl;
      sclkPrev_ff <= sclkLvl;
    end
  end

  // a clock fall landing on the select fall itself is not counted
  assign csFall   = csPrev_ff & ~csLvl;
  assign csRise   = ~csPrev_ff & csLvl;
  assign sclkFall = sclkPrev_ff & ~sclkLvl & ~csLvl & ~csFall;

  assign stConv = (state_ff == ST_CONV);
  assign stTail = (state_ff == ST_TAIL);
  assign stCal  = (state_ff == ST_CAL);

  // edge number of the fall being taken now
  assign nxtCnt = (cnt_ff == CNT_MAX) ? cnt_ff : cnt_ff + 6'h01;

  // conversion step k decides bit 10-k
  assign sarIdx   = 4'(LAST_CONV_EDGE - nxtCnt);
  assign nxtSar   = sap_sar_step(sar_ff, sarIdx, cmpLvl);
  assign convStep = stConv & sclkFall;
  assign convDone = convStep & (nxtCnt == LAST_CONV_EDGE);

  // calibration window differs between the first and later frames
  assign calBase  = firstFrame_ff ? 6'h00 : NRM_CAL_FIRST;
  assign calLast  = firstFrame_ff ? PUP_CAL_LAST : NRM_CAL_LAST;
  assign calRel   = nxtCnt - calBase;
  assign trimIdx  = 4'(CAL_STEPS - calRel);
  assign trimStep = sap_sar_step({5'h00, trial_ff}, trimIdx, cmpLvl);
  assign calStep  = stCal & sclkFall & (calRel != 6'h00) &
                    (calRel <= CAL_STEPS);
  assign calDone  = stCal & sclkFall & (nxtCnt == calLast);
  assign calStartNrm = stTail & sclkFall & ~firstFrame_ff &
                       (nxtCnt == NRM_CAL_FIRST);

  // frame sequencer; select edges take priority over clock edges
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_ACQ;
    end else begin
      case (state_ff)
        ST_ACQ: begin
          if (csFall) state_ff <= firstFrame_ff ? ST_CAL : ST_CONV;
        end
        ST_CONV: begin
          if (csRise) state_ff <= ST_ACQ;
          else if (convDone) state_ff <= ST_TAIL;
        end
        ST_TAIL: begin
          if (csRise) state_ff <= ST_ACQ;
          else if (calStartNrm) state_ff <= ST_CAL;
        end
        ST_CAL: begin
          if (csRise) state_ff <= ST_ACQ;
          else if (calDone) state_ff <= ST_TAIL;
        end
        default: state_ff <= ST_ACQ;
      endcase
    end
  end

  // per-frame falling-edge count
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) cnt_ff <= 6'h00;
    else if (csFall) cnt_ff <= 6'h00;
    else if (sclkFall) cnt_ff <= nxtCnt;
  end

  // sar register doubles as the capacitor dac code
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) sar_ff <= SAR_MSB_CODE;
    else if (csFall) sar_ff <= SAR_MSB_CODE;
    else if (convStep) sar_ff <= nxtSar;
  end

  // trial trim is searched first and committed only at the last edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) trial_ff <= TRIM_MSB_CODE;
    else if (csFall && firstFrame_ff) trial_ff <= TRIM_MSB_CODE;
    else if (calStartNrm) trial_ff <= TRIM_MSB_CODE;
    else if (calStep) trial_ff <= trimStep[4:0];
  end

  // stored offset; a short frame never reaches calDone
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) calTrim_ff <= TRIM_RST_CODE;
    else if (calDone) calTrim_ff <= trial_ff;
  end

  // power-up frame marker, cleared when that frame ends
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) firstFrame_ff <= 1'b1;
    else if (csRise) firstFrame_ff <= 1'b0;
  end

  // bit launched at this fall: zero, ten result bits, then low
  always_comb begin
    nxtSdo = 1'b0;
    if (!firstFrame_ff && (stConv || stTail) &&
        nxtCnt >= FIRST_DATA_EDGE && nxtCnt <= LAST_DATA_EDGE) begin
      nxtSdo = sar_ff[4'(LAST_DATA_EDGE - nxtCnt)];
    end
  end

  // output driver; the first zero goes out with the select fall
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sdoOut_ff <= 1'b0;
      sdoOe_ff  <= 1'b0;
    end else if (csRise) begin
      sdoOut_ff <= 1'b0;
      sdoOe_ff  <= 1'b0;
    end else if (csFall) begin
      sdoOut_ff <= 1'b0;
      sdoOe_ff  <= 1'b1;
    end else if (sclkFall) begin
      sdoOut_ff <= nxtSdo;
    end
  end

  // hold stage ahead of the fifo; a full fifo stalls it, and a second
  // result arriving while it still waits is dropped and flagged
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pendValid_ff <= 1'b0;
      pendData_ff  <= 10'h000;
      overrun_ff   <= 1'b0;
    end else begin
      overrun_ff <= convDone & pendValid_ff & ~pushIf.ready;
      if (convDone && (!pendValid_ff || pushIf.ready)) begin
        pendValid_ff <= 1'b1;
        pendData_ff  <= nxtSar;
      end else if (pushIf.ready) begin
        pendValid_ff <= 1'b0;
      end
    end
  end

  assign pushIf.valid = pendValid_ff;
  assign pushIf.data  = pendData_ff;

  sap_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (ref_clk),
    .reset (reset),
    .inIf  (pushIf.snk),
    .outIf (popIf.src)
  );

  assign resultValid  = popIf.valid;
  assign resultData   = popIf.data;
  assign popIf.ready  = resultReady;

  // acquisition timer, informative only: the host owns the spacing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) acqCnt_ff <= 4'h0;
    else if (!samplerConnect) acqCnt_ff <= 4'h0;
    else if (acqCnt_ff != ACQ_CYC) acqCnt_ff <= acqCnt_ff + 4'h1;
  end

  // sampler tracks only while acquiring or after the conversion
  assign samplerConnect = (state_ff == ST_ACQ) || stTail;
  assign calActive      = stCal;
  assign dacCode        = sar_ff;
  assign trimCode       = stCal ? trial_ff : calTrim_ff;
  assign acqDone        = samplerConnect && (acqCnt_ff == ACQ_CYC);
  assign sdoOut         = sdoOut_ff;
  assign sdoOe          = sdoOe_ff;
  assign resultOverrun  = overrun_ff;

  // checks on the sequencer and the serial output
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sample_hold_a: assert property (csFall |=> !samplerConnect)
    else $error("sampler still connected after select fall");
  conv_isolate_a: assert property (stConv |-> !samplerConnect && !acqDone)
    else $error("inputs connected during conversion");
  conv_reconnect_a: assert property (convDone |=> samplerConnect ##1
                                     (samplerConnect || csFall ||
                                      $past(calStartNrm)))
    else $error("sampler not reconnected after conversion");
  sdo_enable_a: assert property (csFall |=> sdoOe && !sdoOut)
    else $error("output not enabled at select fall");
  sdo_release_a: assert property (csRise |=> !sdoOe ##1 !sdoOe)
    else $error("output still driven after select rise");
  sdo_first_bit_a: assert property (sclkFall && stConv &&
                                    cnt_ff == 6'h01 |=>
                                    sdoOut == sar_ff[9])
    else $error("result msb not launched on second fall");
  sdo_tail_low_a: assert property (sclkFall && cnt_ff >= LAST_DATA_EDGE
                                   |=> !sdoOut)
    else $error("output not low after twelve clocks");
  pup_sdo_low_a: assert property (firstFrame_ff |-> !sdoOut)
    else $error("output high in power-up frame");
  pup_commit_a: assert property ($changed(calTrim_ff) &&
                                 $past(firstFrame_ff) |->
                                 $past(cnt_ff) == 6'h0f)
    else $error("power-up offset stored at wrong edge");
  nrm_commit_a: assert property ($changed(calTrim_ff) &&
                                 !$past(firstFrame_ff) |->
                                 $past(cnt_ff) == 6'h1f)
    else $error("normal offset stored at wrong edge");
  short_cal_a: assert property (csRise && stCal |=> $stable(calTrim_ff))
    else $error("offset changed by a short frame");
  result_code_a: assert property (convDone && !pendValid_ff |=>
                                  pendValid_ff &&
                                  pendData_ff == $past(nxtSar))
    else $error("result word not captured");
  edge_count_a: assert property ($changed(cnt_ff) |->
                                 $past(sclkFall || csFall))
    else $error("edge count moved without a clock or select edge");

  conv_done_c: cover property (convDone ##[1:40] resultValid);
  pup_cal_c: cover property (calDone && firstFrame_ff);
  nrm_cal_c: cover property (calDone && !firstFrame_ff);
  overrun_c: cover property (resultOverrun);
endmodule : sap_serial_port
`default_nettype wire

// ==== hdl/sap_pkg.sv ====
// shared constants, state codes and the successive-approximation step
`default_nettype none
package sap_pkg;
  localparam int         RES_BITS       = 10;
  localparam int         TRIM_BITS      = 5;
  localparam int         FIFO_DEPTH     = 16;
  // falling-edge counter, saturating
  localparam logic [5:0] CNT_MAX        = 6'h3f;
  localparam logic [5:0] FIRST_DATA_EDGE = 6'h02;
  localparam logic [5:0] LAST_CONV_EDGE = 6'h0a;
  localparam logic [5:0] LAST_DATA_EDGE = 6'h0b;
  localparam logic [5:0] PUP_CAL_LAST   = 6'h10;
  localparam logic [5:0] NRM_CAL_FIRST  = 6'h11;
  localparam logic [5:0] NRM_CAL_LAST   = 6'h20;
  localparam logic [5:0] CAL_STEPS      = 6'h05;
  // reset and start codes
  localparam logic [9:0] SAR_MSB_CODE   = 10'h200;
  localparam logic [4:0] TRIM_MSB_CODE  = 5'h10;
  localparam logic [4:0] TRIM_RST_CODE  = 5'h00;
  localparam logic [2:0] SYNC_RST_VAL   = 3'h1;
  // acquisition interval in ref_clk cycles, rounded up
  localparam int         REF_CLK_NS     = 100;
  localparam int         T_ACQ_NS       = 120;
  localparam int         ACQ_CYC_INT    = (T_ACQ_NS + REF_CLK_NS - 1) /
                                          REF_CLK_NS;
  localparam logic [3:0] ACQ_CYC        = 4'(ACQ_CYC_INT);

  typedef enum logic [3:0] {
    ST_ACQ  = 4'h1,
    ST_CONV = 4'h2,
    ST_TAIL = 4'h4,
    ST_CAL  = 4'h8
  } sap_state_type;

  // one binary-search step: drop bit k if the trial was too high,
  // then try the next lower bit
  function automatic logic [9:0] sap_sar_step(input logic [9:0] v,
                                              input logic [3:0] k,
                                              input logic       high);
    logic [9:0] r;
    r = v;
    if (high) r[k] = 1'b0;
    if (k != 4'h0) r[k - 4'h1] = 1'b1;
    return r;
  endfunction : sap_sar_step
endpackage : sap_pkg
`default_nettype wire

// ==== hdl/sap_stream_if.sv ====
// valid/ready word stream between the port logic and its result buffer
`timescale 1ns/10ps
`default_nettype none
interface sap_stream_if #(parameter int WIDTH = 10);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sap_stream_if
`default_nettype wire

// ==== hdl/sap_sync.sv ====
// two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module sap_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // stage1 may go metastable; only stage2 reads it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule : sap_sync
`default_nettype wire

// ==== hdl/sap_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sap_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic reset,
  sap_stream_if.snk inIf,
  sap_stream_if.src outIf
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // full and empty come straight from the occupancy count
  assign inIf.ready  = (count_ff != (AW+1)'(DEPTH));
  assign outIf.valid = (count_ff != '0);
  assign outIf.data  = mem_ff[rdPtr_ff];
  assign push        = inIf.valid & inIf.ready;
  assign pop         = outIf.valid & outIf.ready;

  // storage needs no reset, occupancy guards it
  always_ff @(posedge clk) begin
    if (push) mem_ff[wrPtr_ff] <= inIf.data;
  end

  // pointers wrap naturally, depth is a power of two
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (push) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (pop) rdPtr_ff <= rdPtr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_ff <= '0;
    end else if (push && !pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (pop && !push) begin
      count_ff <= count_ff - 1'b1;
    end
  end
endmodule : sap_fifo
`default_nettype wire

// ==== testbench/sap_host_model.sv ====
// host and analog front-end model facing the serial sampling port
`timescale 1ns/10ps
`default_nettype none
module sap_host_model (
  input  wire logic       ref_clk,
  output logic            csInN,
  output logic            sclkIn,
  output logic            cmpHighIn,
  input  wire logic       sdoOut,
  input  wire logic       sdoOe,
  input  wire logic       samplerConnect,
  input  wire logic       calActive,
  input  wire logic [9:0] dacCode,
  input  wire logic [4:0] trimCode
);
  // a slow link clock only lowers the sample rate, never breaks it
  localparam int HALF_NS = 400;  // 800 ns link period, stands high idle
  logic [9:0] analogIn;
  logic [9:0] heldV;
  logic [4:0] calTarget;
  logic       sdoWire;

  initial begin
    csInN = 1'b1;
    sclkIn = 1'b1;
    analogIn = 10'h000;
    calTarget = 5'h00;
  end

  // sampling caps follow the input only while connected
  always_ff @(posedge ref_clk) begin
    if (samplerConnect) heldV <= analogIn;
  end

  // comparator: high when the trial code sits above the held level, or the trim code above its target while calibrating
  assign cmpHighIn = calActive ? (trimCode > calTarget) : (dacCode > heldV);
  // released line floats so a stale bit cannot pass as data
  assign sdoWire = sdoOe ? sdoOut : 1'bz;

  // one frame; bit k-1 is read just before falling edge k
  task automatic frame(input int n, input logic [9:0] smp,
                       input logic [4:0] tgt, output logic [31:0] bits,
                       output logic oeAll, output logic convOff);
    bits = '0;
    oeAll = 1'b1;
    convOff = 1'b1;
    analogIn = smp;
    calTarget = tgt;
    @(posedge ref_clk);
    #7;  // link edges kept off the system clock phase
    csInN = 1'b0;
    #(2 * HALF_NS);  // setup from select low to first fall
    for (int k = 1; k <= n; k++) begin
      bits[k-1] = sdoWire;
      oeAll = oeAll & sdoOe;
      if (k == 5) convOff = ~samplerConnect;
      if (k == 3) analogIn = ~smp;  // input moves once the sample is held
      sclkIn = 1'b0;  // only the host clock paces the frame
      #HALF_NS;
      sclkIn = 1'b1;
      #HALF_NS;
    end
    csInN = 1'b1;  // well past the last fall
  endtask : frame
endmodule : sap_host_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the serial sampling port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sap_pkg::*;
  logic       ref_clk;
  logic       reset;
  logic       csInN;
  logic       sclkIn;
  logic       cmpHighIn;
  logic       sdoOut;
  logic       sdoOe;
  logic       samplerConnect;
  logic       calActive;
  logic [9:0] dacCode;
  logic [4:0] trimCode;
  logic       acqDone;
  logic [9:0] resultData;
  logic       resultValid;
  logic       resultReady;
  logic       resultOverrun;
  int         failures;
  int         samples_checked;
  int         overruns;
  logic [9:0] expQ[$];
  logic [9:0] corners[4] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff};

  sap_serial_port i_sap_serial_port (
    .ref_clk(ref_clk), .reset(reset), .csInN(csInN), .sclkIn(sclkIn),
    .cmpHighIn(cmpHighIn), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .samplerConnect(samplerConnect), .calActive(calActive),
    .dacCode(dacCode), .trimCode(trimCode), .acqDone(acqDone),
    .resultData(resultData), .resultValid(resultValid),
    .resultReady(resultReady), .resultOverrun(resultOverrun)
  );

  sap_host_model i_sap_host_model (
    .ref_clk(ref_clk), .csInN(csInN), .sclkIn(sclkIn),
    .cmpHighIn(cmpHighIn), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .samplerConnect(samplerConnect), .calActive(calActive),
    .dacCode(dacCode), .trimCode(trimCode)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // serial bits: two zeros, result msb first, then low
  function automatic logic [31:0] exp_bits(input logic [9:0] s,
                                           input int n);
    logic [31:0] r;
    r = '0;
    for (int k = 3; k <= 12; k++) if (k <= n) r[k-1] = s[12-k];
    return r;
  endfunction : exp_bits

  // one frame; conv=0 marks the power-up frame with no result
  task automatic run(input int n, input logic [9:0] s,
                     input logic [4:0] t, input logic conv,
                     input logic keep);
    logic [31:0] b;
    logic        oe;
    logic        off;
    if (keep) expQ.push_back(s);
    i_sap_host_model.frame(n, s, t, b, oe, off);
    check(b, conv ? exp_bits(s, n) : 32'h0);
    check(32'(oe), 32'h1);
    check(32'(off), 32'h1);
    repeat (6) @(posedge ref_clk);
    #7;
    check(32'(sdoOe), 32'h0);
    check(32'({samplerConnect, acqDone}), 32'h3);
  endtask : run

  // stream monitor; negedge sees settled values and one-cycle pulses
  always @(negedge ref_clk) begin
    if (resultOverrun === 1'b1) overruns++;
    if (resultValid === 1'b1 && resultReady === 1'b1) begin
      if (expQ.size() == 0) check(32'(resultData), 32'hffff);
      else check(32'(resultData), 32'(expQ.pop_front()));
    end
  end

  task results;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // watchdog: the tests need well under 1 ms of simulated time
  initial begin
    #3_000_000;
    failures++;
    $display("Error at %0t: watchdog got %h expected %h", $time, 0, 1);
    results;
  end

  initial begin
    int unsigned seedDummy;
    reset = 1'b1;
    resultReady = 1'b0;
    failures = 0;
    samples_checked = 0;
    overruns = 0;
    seedDummy = $urandom(32'hf9d1);
    repeat (2) @(posedge ref_clk);
    #7;
    reset = 1'b0;
    check(32'({sdoOe, samplerConnect}), 32'h1);
    check(32'(trimCode), 32'h0);
    $display("test reset done");
    // power-up frame: output low, offset stored after 16 falls
    run(16, 10'h155, 5'h0b, 1'b0, 1'b0);
    check(32'(trimCode), 32'h0b);
    $display("test power-up calibration done");
    resultReady = 1'b1;
    foreach (corners[i]) run(12, corners[i], 5'h0b, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      run((i == 3) ? 14 : 12, 10'($urandom), 5'h0b, 1'b1, 1'b1);
    end
    $display("test conversions done");
    // one fall short keeps the offset, a full frame replaces it
    run(31, 10'($urandom), 5'h15, 1'b1, 1'b1);
    check(32'(trimCode), 32'h0b);
    run(32, 10'($urandom), 5'h15, 1'b1, 1'b1);
    check(32'(trimCode), 32'h15);
    $display("test normal calibration done");
    // fill: 16 buffered plus 1 held, the 18th is dropped
    resultReady = 1'b0;
    for (int i = 0; i < 18; i++) run(12, 10'($urandom), 5'h15, 1'b1, i < 17);
    check(32'(overruns), 32'h1);
    resultReady = 1'b1;
    repeat (40) @(posedge ref_clk);
    #7;
    check(32'(expQ.size()), 32'h0);
    $display("test buffer fill and drain done");
    // second reset, first frame cut at 15 falls leaves offset at zero
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #7;
    reset = 1'b0;
    run(15, 10'($urandom), 5'h07, 1'b0, 1'b0);
    check(32'(trimCode), 32'h0);
    $display("test short power-up frame done");
    results;
  end
endmodule : tb_top
`default_nettype wire
